//--- adcsr_pkg.sv
// Constants and types shared by the serial readout block
`default_nettype none

package adcsr_pkg;

  // ----------------------------------------------------------------------
  // Sizes, and frame timing counted in serial clock rising edges
  // ----------------------------------------------------------------------
  localparam int DEF_RESOLUTION = 14;
  localparam int FRAME_WORD_BITS = 16;
  localparam logic [4:0] FIRST_BIT_EDGE = 5'h03;
  localparam logic [4:0] TRACK_EDGES = 5'h10;
  localparam logic [1:0] SLEEP_EDGES_M1 = 2'h3;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic STROBE_PREV_RST = 1'h1;
  localparam logic SCK_SEEN_RST = 1'h1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_NAP, PWR_SLEEP} adcsr_pwr_t;

  typedef struct packed {
    logic napping;
    logic sleeping;
  } adcsr_pwr_status_t;

endpackage : adcsr_pkg

`default_nettype wire

//--- adcsr_fifo.sv
// Small FIFO with valid and ready on both sides
`default_nettype none

module adcsr_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = adcsr_pkg::BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
    $error("adcsr_fifo: DEPTH must be 2 or more");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready;
  logic push, pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_in_ready = (next_count != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_o <= next_in_ready;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule : adcsr_fifo

`default_nettype wire

//--- adcsr_readout.sv
// Serial readout of a sampling converter result, device side
`default_nettype none

module adcsr_readout #(
  parameter int RES = adcsr_pkg::DEF_RESOLUTION
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic sample_valid_i,
  input wire logic [RES-1:0] sample_i,
  output logic sample_ready_o,
  input wire logic sck_i,
  input wire logic conversion_strobe_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output adcsr_pkg::adcsr_pwr_status_t pwr_o
);

  if (RES != 12 && RES != 14) begin : g_bad_res
    $error("adcsr_readout: RES must be 12 or 14");
  end

  localparam logic [4:0] LAST_EDGE = 5'(32'(adcsr_pkg::FIRST_BIT_EDGE)
                                        + RES - 1);

  // ----------------------------------------------------------------------
  // System side: buffer and word handshake toward the link
  // ----------------------------------------------------------------------
  logic buf_valid, buf_ready;
  logic [RES-1:0] buf_data;
  logic [RES-1:0] xfer_word, next_xfer_word;
  logic req, next_req, ack_s1, ack_s2;
  logic ack;

  adcsr_fifo #(.WIDTH(RES), .DEPTH(adcsr_pkg::BUF_DEPTH)) u_buf (
    .clk_i(clk_sys_i),
    .srst_i(srst_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(sample_i),
    .in_ready_o(sample_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_ready)
  );

  // Link side may stop its clock; then the buffer fills and stalls source
  assign buf_ready = (req == ack_s2);

  always_comb begin
    next_req = req;
    next_xfer_word = xfer_word;
    if (buf_valid && buf_ready) begin
      next_req = ~req;
      next_xfer_word = buf_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req <= 1'b0;
      xfer_word <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      req <= next_req;
      xfer_word <= next_xfer_word;
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Link side: frame counter and shifter on the serial clock
  // ----------------------------------------------------------------------
  logic rst_k1, rst_k;
  logic req_s1, req_s2, req_s3;
  logic strobe_prev, next_strobe_prev, strobe_rise;
  logic [4:0] cnt, next_cnt, edge_n;
  logic [RES-1:0] sh, next_sh, hold, next_hold;
  logic next_sdo, next_oe, next_ack, sck_tog;

  assign strobe_rise = conversion_strobe_i & ~strobe_prev;
  assign edge_n = cnt + 5'h01;

  always_comb begin
    next_cnt = cnt;
    next_sh = sh;
    next_hold = hold;
    next_ack = ack;
    next_sdo = 1'b0;
    next_oe = 1'b0;
    next_strobe_prev = conversion_strobe_i;
    if (req_s2 != req_s3) begin
      next_hold = xfer_word;
      next_ack = req_s2;
    end
    if (cnt == adcsr_pkg::CNT_RST) begin
      if (strobe_rise) begin
        next_cnt = 5'h01;
        next_sh = hold;
      end
    end else begin
      // Back to idle after 16 further edges
      next_cnt = (cnt == adcsr_pkg::TRACK_EDGES) ? adcsr_pkg::CNT_RST
                                                 : edge_n;
      if (edge_n >= adcsr_pkg::FIRST_BIT_EDGE && edge_n <= LAST_EDGE) begin
        next_sdo = sh[RES-1];
        next_oe = 1'b1;
        next_sh = {sh[RES-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sck_i) begin
    rst_k1 <= srst_i;
    rst_k <= rst_k1;
    req_s1 <= req;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  always_ff @(posedge sck_i) begin
    if (rst_k) begin
      cnt <= adcsr_pkg::CNT_RST;
      sh <= '0;
      hold <= '0;
      ack <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      strobe_prev <= adcsr_pkg::STROBE_PREV_RST;
      sck_tog <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sh <= next_sh;
      hold <= next_hold;
      ack <= next_ack;
      sdo_o <= next_sdo;
      sdo_oe_o <= next_oe;
      strobe_prev <= next_strobe_prev;
      sck_tog <= ~sck_tog;
    end
  end

  // ----------------------------------------------------------------------
  // System side: power-down tracking from strobe and serial edges
  // ----------------------------------------------------------------------
  logic stb_s1, stb_s2, stb_s3, tog_s1, tog_s2, tog_s3;
  logic stb_rise, sck_ev;
  logic sck_seen, next_sck_seen;
  logic [1:0] nap_cnt, next_nap_cnt;
  adcsr_pkg::adcsr_pwr_t pwr, next_pwr;
  adcsr_pkg::adcsr_pwr_status_t next_pwr_o;

  assign stb_rise = stb_s2 & ~stb_s3;
  assign sck_ev = tog_s2 ^ tog_s3;

  always_comb begin
    next_pwr = pwr;
    next_nap_cnt = nap_cnt;
    next_sck_seen = sck_ev | (sck_seen & ~stb_rise);
    unique case (pwr)
      adcsr_pkg::PWR_ACTIVE: begin
        if (stb_rise && !sck_seen && !sck_ev) begin
          next_pwr = adcsr_pkg::PWR_NAP;
          next_nap_cnt = 2'h0;
        end
      end
      adcsr_pkg::PWR_NAP: begin
        if (sck_ev && !stb_s2) begin
          next_pwr = adcsr_pkg::PWR_ACTIVE;
        end else if (sck_ev) begin
          next_nap_cnt = nap_cnt + 2'h1;
          if (nap_cnt == adcsr_pkg::SLEEP_EDGES_M1) begin
            next_pwr = adcsr_pkg::PWR_SLEEP;
          end
        end
      end
      adcsr_pkg::PWR_SLEEP: begin
        if (sck_ev && !stb_s2) begin
          next_pwr = adcsr_pkg::PWR_ACTIVE;
        end
      end
    endcase
    next_pwr_o.napping = (next_pwr == adcsr_pkg::PWR_NAP);
    next_pwr_o.sleeping = (next_pwr == adcsr_pkg::PWR_SLEEP);
  end

  always_ff @(posedge clk_sys_i) begin
    stb_s1 <= conversion_strobe_i;
    stb_s2 <= stb_s1;
    tog_s1 <= sck_tog;
    tog_s2 <= tog_s1;
    if (srst_i) begin
      stb_s3 <= 1'b1;
      tog_s3 <= 1'b0;
      pwr <= adcsr_pkg::PWR_ACTIVE;
      nap_cnt <= 2'h0;
      sck_seen <= adcsr_pkg::SCK_SEEN_RST;
      pwr_o <= '0;
    end else begin
      stb_s3 <= stb_s2;
      tog_s3 <= tog_s2;
      pwr <= next_pwr;
      nap_cnt <= next_nap_cnt;
      sck_seen <= next_sck_seen;
      pwr_o <= next_pwr_o;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [4:0] oe_run;
  always_ff @(posedge sck_i) begin
    if (rst_k || !sdo_oe_o) begin
      oe_run <= 5'h01;
    end else begin
      oe_run <= oe_run + 5'h01;
    end
  end

  a_reset_hiz: assert property (@(posedge sck_i) disable iff (rst_k)
    $fell(rst_k) |-> !sdo_oe_o)
    else $error("data output driven right after reset");
  a_idle_hiz: assert property (@(posedge sck_i) disable iff (rst_k)
    (cnt == 5'h00 && !strobe_rise) |=> !sdo_oe_o)
    else $error("data output driven without a conversion");
  a_msb_third_edge: assert property (@(posedge sck_i) disable iff (rst_k)
    (cnt == 5'h00 && strobe_rise) |=> !sdo_oe_o ##1 !sdo_oe_o
      ##1 (sdo_oe_o && sdo_o == $past(sh[RES-1])))
    else $error("first result bit not on third edge");
  a_burst_len: assert property (@(posedge sck_i) disable iff (rst_k)
    (sdo_oe_o && !next_oe) |-> oe_run == 5'(RES))
    else $error("wrong number of result bits");
  a_no_restart: assert property (@(posedge sck_i) disable iff (rst_k)
    (cnt != 5'h00 && cnt != 5'h10) |=> cnt == $past(cnt) + 5'h01)
    else $error("strobe restarted a running conversion");
  a_frame_end: assert property (@(posedge sck_i) disable iff (rst_k)
    (cnt == 5'h00 && strobe_rise) |=> ##15 (cnt == 5'h10)
      ##1 (cnt == 5'h00 && !sdo_oe_o))
    else $error("frame did not end after 17 edges");
  a_nap_entry: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (pwr == adcsr_pkg::PWR_ACTIVE && stb_rise && !sck_seen && !sck_ev)
      |=> pwr == adcsr_pkg::PWR_NAP ##1 pwr_o.napping)
    else $error("double strobe did not enter nap");
  a_sleep_entry: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (pwr == adcsr_pkg::PWR_NAP && sck_ev && stb_s2 && nap_cnt == 2'h3)
      |=> ##1 pwr_o.sleeping)
    else $error("fourth serial edge did not enter sleep");
  a_xfer_stable: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (req != ack_s2) |=> $stable(xfer_word) || (req == $past(ack_s2)))
    else $error("word changed during crossing");

  c_frame: cover property (@(posedge sck_i) disable iff (rst_k)
    (cnt == 5'h00 && strobe_rise) ##17 strobe_rise);
  c_nap: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    pwr_o.napping);
  c_sleep_wake: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    pwr_o.sleeping ##[1:1000] !pwr_o.sleeping);
  c_backpressure: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    sample_valid_i && !sample_ready_o);

endmodule : adcsr_readout

`default_nettype wire

//--- adcsr_host_model.sv
// Behavioural host serial port that clocks the link and captures words
`default_nettype none

module adcsr_host_model (
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sck_o,
  output logic strobe_o,
  output logic [15:0] word_o,
  output logic oe_end_o,
  output int oe_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  logic pin;
  logic [15:0] shreg = 16'h0000;

  initial begin
    sck_o = 1'b0;
    strobe_o = 1'b0;
    word_o = 16'h0000;
    oe_end_o = 1'b0;
    oe_cnt_o = 0;
  end

  // Released line shows the inverse of its last driven level
  always @(sdo_i or sdo_oe_i) begin
    if (sdo_oe_i) last = sdo_i;
  end
  assign pin = sdo_oe_i ? sdo_i : ~last;

  // ------------------------------------------------------------------
  // Link cycles; the clock stands low between calls
  // ------------------------------------------------------------------
  task automatic pulse(input logic s);
    #16 strobe_o = s;
    #16 sck_o = 1'b1;
    #32 shreg = {shreg[14:0], pin};
    oe_end_o = sdo_oe_i;
    if (sdo_oe_i) oe_cnt_o++;
    sck_o = 1'b0;
  endtask : pulse

  task automatic idle(input int n);
    oe_cnt_o = 0;
    repeat (n) pulse(1'b0);
  endtask : idle

  task automatic frame(input int n, input int again);
    oe_cnt_o = 0;
    for (int i = 1; i <= n; i++) begin
      pulse(i == 1 || i == again);
      if (i == 16) word_o = shreg;
    end
  endtask : frame

  // Two strobe rises with no clock edge between them
  task automatic nap();
    #16 strobe_o = 1'b1;
    #16 strobe_o = 1'b0;
    #16 strobe_o = 1'b1;
  endtask : nap
endmodule : adcsr_host_model

`default_nettype wire

//--- adc_serial_readout_bench.sv
// Self-checking bench for the serial readout block
`default_nettype none

module adc_serial_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sample_valid = 1'b0;
  logic [13:0] sample = 14'h0000;
  logic [13:0] last_word = 14'h0000;
  logic sample_ready, sck, strobe, sdo, sdo_oe, oe_end;
  logic [15:0] word;
  int oe_cnt;
  int bad_count = 0;
  int samples_checked = 0;
  adcsr_pkg::adcsr_pwr_status_t pwr;

  always #2 clk_sys = ~clk_sys;

  adcsr_readout #(.RES(14)) u_adcsr_readout (
    .clk_sys_i(clk_sys), .srst_i(srst), .sample_valid_i(sample_valid),
    .sample_i(sample), .sample_ready_o(sample_ready), .sck_i(sck),
    .conversion_strobe_i(strobe), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .pwr_o(pwr));

  adcsr_host_model u_adcsr_host_model (
    .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .strobe_o(strobe),
    .word_o(word), .oe_end_o(oe_end), .oe_cnt_o(oe_cnt));

  task automatic check_word(input string what, input logic [13:0] exp,
                            input logic [13:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic give_up();
    bad_count++;
    final_report();
  endtask : give_up

  task automatic push(input logic [13:0] w);
    int n;
    n = 0;
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample <= w;
    @(posedge clk_sys);
    while (sample_ready !== 1'b1) begin
      n++;
      if (n > 100) give_up();
      @(posedge clk_sys);
    end
    sample_valid <= 1'b0;
    last_word = w;
  endtask : push

  task automatic check_frame(input logic [13:0] w);
    check_word("frame word", w, word[13:0]);
    check_word("driven bits", 14'h000E, 14'(oe_cnt));
    check_word("oe after frame", 14'h0000, {13'h0000, oe_end});
  endtask : check_frame

  task automatic wait_pwr(input logic [1:0] exp);
    int n;
    n = 0;
    while (pwr !== exp) begin
      n++;
      if (n > 50) give_up();
      @(posedge clk_sys);
    end
    check_word("power status", {12'h000, exp}, {12'h000, pwr});
  endtask : wait_pwr

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    u_adcsr_host_model.idle(6);
    @(posedge clk_sys);
    srst <= 1'b0;
    u_adcsr_host_model.idle(4);
    check_word("idle driven bits", 14'h0000, 14'(oe_cnt));
    check_word("oe before strobe", 14'h0000, {13'h0000, sdo_oe});
    wait_pwr(2'h0);
  endtask : t_reset

  task automatic t_frame();
    push(14'h2A5C);
    u_adcsr_host_model.idle(8);
    u_adcsr_host_model.frame(17, 0);
    check_frame(14'h2A5C);
  endtask : t_frame

  task automatic t_restrobe();
    push(14'h1003);
    u_adcsr_host_model.idle(8);
    u_adcsr_host_model.frame(17, 5);
    check_frame(14'h1003);
    u_adcsr_host_model.frame(17, 0);
    check_frame(14'h1003);
  endtask : t_restrobe

  task automatic t_fill();
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      sample_valid <= 1'b1;
      sample <= 14'h3FF0 + 14'(i);
      @(posedge clk_sys);
      if (sample_ready === 1'b1) last_word = 14'h3FF0 + 14'(i);
    end
    sample_valid <= 1'b0;
    @(posedge clk_sys);
    check_word("ready when full", 14'h0000, {13'h0000, sample_ready});
    u_adcsr_host_model.idle(40);
    @(posedge clk_sys);
    check_word("ready drained", 14'h0001, {13'h0000, sample_ready});
    u_adcsr_host_model.frame(17, 0);
    check_frame(last_word);
  endtask : t_fill

  task automatic t_power();
    u_adcsr_host_model.nap();
    wait_pwr(2'h2);
    repeat (4) u_adcsr_host_model.pulse(1'b1);
    wait_pwr(2'h1);
    u_adcsr_host_model.pulse(1'b0);
    wait_pwr(2'h0);
    u_adcsr_host_model.idle(20);
  endtask : t_power

  // Reset in mid-run that cuts a frame while the data pin is driven
  task automatic t_rereset();
    push(14'h0A53);
    u_adcsr_host_model.idle(8);
    u_adcsr_host_model.pulse(1'b1);
    repeat (4) u_adcsr_host_model.pulse(1'b0);
    check_word("oe in cut frame", 14'h0001, {13'h0000, sdo_oe});
    @(posedge clk_sys);
    srst <= 1'b1;
    u_adcsr_host_model.idle(4);
    @(posedge clk_sys);
    srst <= 1'b0;
    u_adcsr_host_model.idle(4);
    check_word("oe after reset", 14'h0000, {13'h0000, sdo_oe});
    check_word("driven after reset", 14'h0000, 14'(oe_cnt));
    check_word("ready after reset", 14'h0001, {13'h0000, sample_ready});
    wait_pwr(2'h0);
  endtask : t_rereset

  initial begin
    t_reset();
    t_frame();
    t_restrobe();
    t_fill();
    t_power();
    t_rereset();
    t_frame();
    final_report();
  end
endmodule : adc_serial_readout_bench

`default_nettype wire
